// *** hdl/bcc_mult.sv ***
// Commutation delay multiplier, registered result
`timescale 1ns/100ps
module bcc_mult
   import bcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   bcc_mul_if.mul   mif
);
   logic [WW+ZW-1:0] prod;
   logic [ZW-1:0]    res_ff;

   // Full product, scaled down by 256 through the bit select
   assign prod = {{ZW{1'b0}}, mif.weight} * {{WW{1'b0}}, mif.ztime};
   assign mif.result = res_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_ff <= '0;
      end else begin
         res_ff <= prod[WW+ZW-1:DIV_SHIFT];
      end
   end
endmodule : bcc_mult

// *** hdl/bcc_top.sv ***
// Commutation output configuration block with Avalon-MM registers
`timescale 1ns/100ps
module bcc_top
   import bcc_pkg::*;
(
   input  wire logic           CLK,
   input  wire logic           RST_N,
   input  wire logic [5:0]     ADDRESS,
   input  wire logic           READ,
   input  wire logic           WRITE,
   input  wire logic [3:0]     BYTEENABLE,
   input  wire logic [31:0]    WRITEDATA,
   output logic      [31:0]    READDATA,
   output logic                WAITREQUEST,
   input  wire logic           COMM_IN,
   input  wire logic           HW_DEMAG_IN,
   input  wire logic           SIM_DEMAG_IN,
   input  wire logic           CMP_IN,
   input  wire logic [ZW-1:0]  ZC_TIMER,
   input  wire logic           CUR_LIM,
   input  wire logic           PWM_IN,
   input  wire logic           OPT_RST_LVL,
   output logic      [NPH-1:0] PHASE_OUT,
   output logic                PWM_OFF,
   output logic                COMM_EVT,
   output logic                DEMAG_EVT,
   output logic                ZERO_EVT,
   output logic                IRQ
);
   ////////////////////////////////////////////////////////////////////////
   logic [6:0]     ctrl_ff;
   logic [6:0]     oc_pre_ff;
   logic [6:0]     oc_act_ff;
   logic [NPH-1:0] ph_pre_ff;
   logic [NPH-1:0] ph_act_ff;
   logic [NPH-1:0] pol_ff;
   logic [WW-1:0]  wght_ff;
   logic [ZW-1:0]  zlat_ff;
   logic [ZW-1:0]  zprv_ff;
   logic [3:0]     stat_ff;
   logic [3:0]     mask_ff;
   logic           cmp_ff;
   logic           wait_ff;
   logic [31:0]    rdata_ff;
   bcc_step_t      step_ff;
   bcc_step_t      nxt_step;
   logic           wr_acc;
   logic           rd_acc;
   logic           ph_wr;
   logic           direct;
   logic           c_evt;
   logic           d_evt;
   logic           z_evt;
   logic           oc_en;
   logic           oc_trip;
   logic           pwm_kill;
   logic           low_sel;
   logic [NPH-1:0] nxt_out;
   logic [3:0]     ev_vec;
   bcc_mul_if      mif ();

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: every access waits one cycle, then completes
   assign wr_acc = WRITE && !wait_ff && BYTEENABLE[0];
   assign rd_acc = READ && wait_ff;
   assign ph_wr  = wr_acc && (ADDRESS == OFS_PHASE);

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= !((READ || WRITE) && wait_ff);
      end
   end

   // Read data is latched in the first cycle so it stands at the release
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_ff <= '0;
      end else if (rd_acc) begin
         unique case (ADDRESS)
            OFS_CTRL:   rdata_ff <= {25'h0, ctrl_ff};
            OFS_OUTCTL: rdata_ff <= {25'h0, oc_pre_ff};
            OFS_OUTACT: rdata_ff <= {25'h0, oc_act_ff};
            OFS_PHASE:  rdata_ff <= {26'h0, ph_act_ff};
            OFS_POL:    rdata_ff <= {26'h0, pol_ff};
            OFS_WGHT:   rdata_ff <= {24'h000000, wght_ff};
            OFS_ZLAT:   rdata_ff <= {16'h0000, zlat_ff};
            OFS_ZPRV:   rdata_ff <= {16'h0000, zprv_ff};
            OFS_DELAY:  rdata_ff <= {16'h0000, mif.result};
            OFS_STAT:   rdata_ff <= {28'h0000000, stat_ff};
            OFS_MASK:   rdata_ff <= {28'h0000000, mask_ff};
            default:    rdata_ff <= '0; // Unmapped reads as zero
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register; a trip drops the enable and beats a software set
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_ff <= CTRL_RST;
      end else begin
         if (wr_acc && ADDRESS == OFS_CTRL) begin
            ctrl_ff <= WRITEDATA[6:0];
         end
         if (oc_trip) begin
            ctrl_ff[CT_MOE] <= 1'b0;
         end
      end
   end

   // Output control byte; top bit is reserved and never stored
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         oc_pre_ff <= OUTCTL_RST;
      end else if (wr_acc && ADDRESS == OFS_OUTCTL) begin
         oc_pre_ff <= WRITEDATA[6:0];
      end
   end

   // Plain registers: phase preload, polarity, weight
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ph_pre_ff <= '0;
         pol_ff    <= '0;
         wght_ff   <= '0;
      end else if (wr_acc) begin
         if (ADDRESS == OFS_PHASE) ph_pre_ff <= WRITEDATA[NPH-1:0];
         if (ADDRESS == OFS_POL)   pol_ff    <= WRITEDATA[NPH-1:0];
         if (ADDRESS == OFS_WGHT)  wght_ff   <= WRITEDATA[WW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Commutation source: timer event, or a phase write in direct mode
   assign direct = ctrl_ff[CT_DIRECT];
   assign c_evt  = direct ? ph_wr : COMM_IN;

   // Preload transfer; direct mode takes the fresh phase value at once
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         oc_act_ff <= OUTCTL_RST;
         ph_act_ff <= '0;
      end else if (c_evt) begin
         oc_act_ff <= oc_pre_ff;
         ph_act_ff <= direct ? WRITEDATA[NPH-1:0] : ph_pre_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event qualification by the active masks and edge choice
   assign d_evt = (HW_DEMAG_IN && oc_act_ff[OC_HDM])
               || (SIM_DEMAG_IN && oc_act_ff[OC_SDM]);
   assign z_evt = oc_act_ff[OC_EDGE] ? (CMP_IN && !cmp_ff)
                                     : (!CMP_IN && cmp_ff);

   // Zero-crossing capture keeps the previous time as well
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cmp_ff  <= 1'b0;
         zlat_ff <= '0;
         zprv_ff <= '0;
      end else begin
         cmp_ff <= CMP_IN;
         if (z_evt) begin
            zprv_ff <= zlat_ff;
            zlat_ff <= ZC_TIMER;
         end
      end
   end

   // Delay multiplier fed with the capture the select bit picks
   assign mif.weight = wght_ff;
   assign mif.ztime  = ctrl_ff[CT_CAPSEL] ? zlat_ff : zprv_ff;

   bcc_mult u_mult (
      .clk   (CLK),
      .rst_n (RST_N),
      .mif   (mif)
   );

   ////////////////////////////////////////////////////////////////////////
   // Step tracking; sensor mode has no demagnetization step
   always_comb begin
      nxt_step = step_ff;
      if (c_evt) begin
         nxt_step = STEP_CD;
      end else begin
         unique case (step_ff)
            STEP_CD: begin
               if (ctrl_ff[CT_SENSOR] && z_evt) nxt_step = STEP_ZC;
               else if (!ctrl_ff[CT_SENSOR] && d_evt) nxt_step = STEP_DZ;
            end
            STEP_DZ: begin
               if (z_evt) nxt_step = STEP_ZC;
            end
            STEP_ZC: nxt_step = STEP_ZC;
            default: nxt_step = STEP_CD;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         step_ff <= STEP_CD;
      end else begin
         step_ff <= nxt_step;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Overcurrent: three-PWM outputs need voltage mode for the trip
   assign oc_en = oc_pre_ff[OC_OCV]
               && !(ctrl_ff[CT_3PWM] && ctrl_ff[CT_VCS]);
   assign oc_trip  = CUR_LIM && ctrl_ff[CT_CURRENT_LIMIT_IRQ_MASK] && oc_en;
   assign pwm_kill = CUR_LIM && !oc_trip;

   // Which channel side carries PWM in the present step
   always_comb begin
      low_sel = oc_act_ff[OC_OS0];
      if (!direct) begin
         unique case (step_ff)
            STEP_CD: low_sel = oc_act_ff[OC_OS2];
            STEP_DZ: low_sel = oc_act_ff[OC_OS1];
            STEP_ZC: low_sel = oc_act_ff[OC_OS0];
            default: low_sel = oc_act_ff[OC_OS0];
         endcase
      end
   end

   // Even outputs are high channels, odd ones low channels
   always_comb begin
      nxt_out = '0;
      for (int i = 0; i < NPH; i++) begin
         if (!ctrl_ff[CT_MOE]) begin
            nxt_out[i] = OPT_RST_LVL;
         end else begin
            nxt_out[i] = (ph_act_ff[i] && ((i % 2 == 1) != low_sel
                          || (PWM_IN && !pwm_kill))) ^ pol_ff[i];
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PHASE_OUT <= '0;
         PWM_OFF   <= 1'b0;
         COMM_EVT  <= 1'b0;
         DEMAG_EVT <= 1'b0;
         ZERO_EVT  <= 1'b0;
      end else begin
         PHASE_OUT <= nxt_out;
         PWM_OFF   <= pwm_kill;
         COMM_EVT  <= c_evt;
         DEMAG_EVT <= d_evt;
         ZERO_EVT  <= z_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky status; a new event wins over a write-one clear
   assign ev_vec = {CUR_LIM && ctrl_ff[CT_CURRENT_LIMIT_IRQ_MASK], z_evt, d_evt, c_evt};

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         stat_ff <= '0;
         mask_ff <= '0;
      end else begin
         if (wr_acc && ADDRESS == OFS_MASK) mask_ff <= WRITEDATA[3:0];
         if (wr_acc && ADDRESS == OFS_STAT) begin
            stat_ff <= (stat_ff & ~WRITEDATA[3:0]) | ev_vec;
         end else begin
            stat_ff <= stat_ff | ev_vec;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(stat_ff & mask_ff);
      end
   end

   assign READDATA    = rdata_ff;
   assign WAITREQUEST = wait_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   chk_disable_level: assert property (@(posedge CLK) disable iff (!RST_N)
      !ctrl_ff[CT_MOE] |=> PHASE_OUT == {NPH{$past(OPT_RST_LVL)}})
      else $error("phase outputs not at reset level while disabled");
   chk_delay_value: assert property (@(posedge CLK) disable iff (!RST_N)
      ##1 mif.result == 16'(({8'h00, $past(wght_ff)} * ({8'h00,
      $past(ctrl_ff[CT_CAPSEL]) ? $past(zlat_ff) : $past(zprv_ff)}))
      >> 8))
      else $error("commutation delay mismatch");
   chk_preload_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      !c_evt |=> $stable(oc_act_ff))
      else $error("active control changed without commutation");
   chk_preload_take: assert property (@(posedge CLK) disable iff (!RST_N)
      c_evt |=> oc_act_ff == $past(oc_pre_ff))
      else $error("preload not taken at commutation");
   chk_zero_edge: assert property (@(posedge CLK) disable iff (!RST_N)
      ($rose(CMP_IN) && oc_act_ff[OC_EDGE]) |=> ZERO_EVT)
      else $error("rising zero crossing missed");
   chk_hw_demag: assert property (@(posedge CLK) disable iff (!RST_N)
      (!oc_act_ff[OC_HDM] && !oc_act_ff[OC_SDM]) |=> !DEMAG_EVT)
      else $error("demagnetization event while masked");
   chk_sim_demag: assert property (@(posedge CLK) disable iff (!RST_N)
      (SIM_DEMAG_IN && oc_act_ff[OC_SDM]) |=> DEMAG_EVT)
      else $error("simulated demagnetization event lost");
   chk_trip_drop: assert property (@(posedge CLK) disable iff (!RST_N)
      oc_trip |=> !ctrl_ff[CT_MOE] ##1
      PHASE_OUT == {NPH{$past(OPT_RST_LVL)}})
      else $error("overcurrent trip did not disable outputs");
   chk_limit_pwm: assert property (@(posedge CLK) disable iff (!RST_N)
      (CUR_LIM && !ctrl_ff[CT_CURRENT_LIMIT_IRQ_MASK]) |=> PWM_OFF && !stat_ff[ST_CURRENT_LIMIT_IRQ_MASK]
      || $past(stat_ff[ST_CURRENT_LIMIT_IRQ_MASK]))
      else $error("current limit handling wrong with mask clear");
   chk_three_pwm: assert property (@(posedge CLK) disable iff (!RST_N)
      (CUR_LIM && ctrl_ff[CT_3PWM] && ctrl_ff[CT_VCS]) |=> PWM_OFF)
      else $error("trip in current mode with three outputs");
   chk_direct_comm: assert property (@(posedge CLK) disable iff (!RST_N)
      (direct && ph_wr) |=> COMM_EVT && step_ff == STEP_CD)
      else $error("direct phase write gave no commutation");
endmodule : bcc_top

// *** shared/bcc_mul_if.sv ***
// Carrier between the control logic and the delay multiplier
`timescale 1ns/100ps
interface bcc_mul_if;
   import bcc_pkg::*;
   logic [WW-1:0] weight;
   logic [ZW-1:0] ztime;
   logic [ZW-1:0] result;
   modport src (output weight, output ztime, input result);
   modport mul (input weight, input ztime, output result);
endinterface : bcc_mul_if

// *** shared/bcc_pkg.sv ***
// Constants, register map and types of the commutation output block
//
// Behaviour
// - Enable clear gives reset level; direct access follows phase state.
// - Delay is weight times selected zero-cross time, divided by 256.
// - Preload bits apply at commutation, or on direct-mode phase write; the overcurrent bit applies at once.
// - Edge select 0 detects falling zero crossings, 1 detects rising ones.
// - Hardware demagnetization events pass only while their mask is one.
// - Simulated demagnetization events pass only while their mask is one.
// - Voltage-mode overcurrent bit turns overcurrent protection on or off.
// - Limit without trip turns PWM off; interrupt only when mask is set.
// - Flag, mask and overcurrent bit set: enable drops, interrupt raised.
// - Three-PWM outputs keep overcurrent handling only in voltage mode.
// - Sensorless: top, middle, low step bit set puts PWM on low channels.
// - Direct-mode phase write commutates; PWM side follows low step bit.
package bcc_pkg;
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL   = 6'h00;
   localparam logic [5:0] OFS_OUTCTL = 6'h04;
   localparam logic [5:0] OFS_OUTACT = 6'h08;
   localparam logic [5:0] OFS_PHASE  = 6'h0C;
   localparam logic [5:0] OFS_POL    = 6'h10;
   localparam logic [5:0] OFS_WGHT   = 6'h14;
   localparam logic [5:0] OFS_ZLAT   = 6'h18;
   localparam logic [5:0] OFS_ZPRV   = 6'h1C;
   localparam logic [5:0] OFS_DELAY  = 6'h20;
   localparam logic [5:0] OFS_STAT   = 6'h24;
   localparam logic [5:0] OFS_MASK   = 6'h28;
   // Control register fields
   localparam int CT_CAPSEL = 0;
   localparam int CT_MOE    = 1;
   localparam int CT_DIRECT = 2;
   localparam int CT_VCS    = 3;
   localparam int CT_SENSOR = 4;
   localparam int CT_3PWM   = 5;
   localparam int CT_CURRENT_LIMIT_IRQ_MASK   = 6;
   // Output control byte fields
   localparam int OC_OS0  = 0;
   localparam int OC_OS1  = 1;
   localparam int OC_OS2  = 2;
   localparam int OC_OCV  = 3;
   localparam int OC_SDM  = 4;
   localparam int OC_HDM  = 5;
   localparam int OC_EDGE = 6;
   // Status and mask fields
   localparam int ST_COMM  = 0;
   localparam int ST_DEMAG = 1;
   localparam int ST_ZERO  = 2;
   localparam int ST_CURRENT_LIMIT_IRQ_MASK  = 3;
   // Widths, reset values, multiplier scaling
   localparam int NPH = 6;
   localparam int ZW  = 16;
   localparam int WW  = 8;
   localparam int DIV_SHIFT = 8;
   localparam logic [6:0] OUTCTL_RST = 7'h00;
   localparam logic [6:0] CTRL_RST   = 7'h00;
   // Commutation step, Gray coded along C, D, Z
   typedef enum logic [1:0] {
      STEP_CD = 2'b00,
      STEP_DZ = 2'b01,
      STEP_ZC = 2'b11
   } bcc_step_t;
endpackage : bcc_pkg

// *** testbench/bcc_bridge_model.sv ***
// Inverter bridge and motor model seen from the phase outputs
`timescale 1ns/100ps
module bcc_bridge_model (
   input  wire logic [5:0] gate,
   input  wire logic       bemf_pos,
   input  wire logic       load_fault,
   output logic            cmp_level,
   output logic            over_cur
);
   // Comparator on the floating phase follows the back-EMF sign; the
   // gates only steer current, so they do not feed back into it here
   assign cmp_level = bemf_pos;
   // Fault current flows only while some gate conducts, so a trip that
   // drops every output also ends the limit condition
   assign over_cur = load_fault && (gate != 6'h00);
endmodule : bcc_bridge_model

// *** testbench/bldc_commutation_output_config_test.sv ***
// Self-checking bench for the commutation output block
`timescale 1ns/100ps
module bldc_commutation_output_config_test
   import bcc_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [5:0]  address = 6'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [2:0]  ev = 3'h0;
   logic        bemf = 1'b1;
   logic        fault = 1'b0;
   logic        pwm = 1'b0;
   logic        opt = 1'b0;
   logic [15:0] ztime = 16'h0000;
   logic [31:0] rdata;
   logic [5:0]  phase;
   logic        waitreq, cmp, cur, pwm_off, comm_evt, demag_evt;
   logic        zero_evt, irq;
   int          num_errors = 0;
   int          n_tests = 0;
   int          n_comm = 0, n_demag = 0, n_zero = 0, cyc = 0;
   //////////////////////////////
   // Clock, design and far side
   always #25 clk = ~clk;
   bcc_top u_dut (.CLK(clk), .RST_N(rst_n), .ADDRESS(address),
      .READ(read), .WRITE(write), .BYTEENABLE(4'hF), .WRITEDATA(wdata),
      .READDATA(rdata), .WAITREQUEST(waitreq), .COMM_IN(ev[0]),
      .HW_DEMAG_IN(ev[1]), .SIM_DEMAG_IN(ev[2]), .CMP_IN(cmp),
      .ZC_TIMER(ztime), .CUR_LIM(cur), .PWM_IN(pwm), .OPT_RST_LVL(opt),
      .PHASE_OUT(phase), .PWM_OFF(pwm_off), .COMM_EVT(comm_evt),
      .DEMAG_EVT(demag_evt), .ZERO_EVT(zero_evt), .IRQ(irq));
   bcc_bridge_model u_bridge (.gate(phase), .bemf_pos(bemf),
      .load_fault(fault), .cmp_level(cmp), .over_cur(cur));
   // Event counters; counting beats cycle matching since some events lag
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (comm_evt === 1'b1) n_comm <= n_comm + 1;
      if (demag_evt === 1'b1) n_demag <= n_demag + 1;
      if (zero_evt === 1'b1) n_zero <= n_zero + 1;
   end
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clk) begin
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   //////////////////////////////
   // Tasks
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle
   // One access, held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      address <= a;
      wdata <= d;
      write <= wr;
      read <= ~wr;
      do @(posedge clk); while (waitreq !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("register %h", a), e, rdata);
   endtask : rd
   task automatic ph(input logic [5:0] e);
      idle(2);
      chk("phase outputs", 32'(e), 32'(phase));
   endtask : ph
   task automatic pulse(input int k);
      @(posedge clk);
      ev[k] <= 1'b1;
      @(posedge clk);
      ev[k] <= 1'b0;
      idle(2);
   endtask : pulse
   task automatic cmp_to(input logic v, input logic [15:0] t);
      @(posedge clk);
      ztime <= t;
      bemf <= v;
      idle(3);
   endtask : cmp_to
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   //////////////////////////////
   // Test sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_CTRL, 32'h0);
      rd(OFS_OUTCTL, 32'h0);
      rd(OFS_STAT, 32'h0);
      rd(6'h3C, 32'h0);
      ph(6'h00);
      opt <= 1'b1;
      ph(6'h3F);
      $display("test reset done");
      // Captures, multiplier and edge choice
      wr(OFS_WGHT, 32'h80);
      cmp_to(1'b0, 16'h1000);
      cmp_to(1'b1, 16'h2000);
      cmp_to(1'b0, 16'h3000);
      chk("zero events", 2, n_zero);
      rd(OFS_ZLAT, 32'h3000);
      rd(OFS_ZPRV, 32'h1000);
      rd(OFS_DELAY, 32'h0800);
      wr(OFS_CTRL, 32'h01);
      idle(2);
      rd(OFS_DELAY, 32'h1800);
      wr(OFS_OUTCTL, 32'h40);
      cmp_to(1'b1, 16'h4000);
      chk("zero events", 2, n_zero);
      pulse(0);
      rd(OFS_OUTACT, 32'h40);
      cmp_to(1'b0, 16'h4100);
      cmp_to(1'b1, 16'h4200);
      chk("zero events", 3, n_zero);
      $display("test zero crossing done");
      // Demagnetization masks, preloaded
      wr(OFS_OUTCTL, 32'h30);
      pulse(1);
      chk("demag events", 0, n_demag);
      pulse(0);
      rd(OFS_OUTACT, 32'h30);
      pulse(1);
      chk("demag events", 1, n_demag);
      pulse(0);
      pulse(2);
      chk("demag events", 2, n_demag);
      wr(OFS_OUTCTL, 32'h00);
      pulse(0);
      pulse(2);
      pulse(1);
      chk("demag events", 2, n_demag);
      $display("test demag done");
      // Sensorless steps: low, high, low channel PWM
      wr(OFS_PHASE, 32'h3F);
      wr(OFS_OUTCTL, 32'h25);
      wr(OFS_CTRL, 32'h02);
      pulse(0);
      ph(6'h15);
      pulse(1);
      ph(6'h2A);
      cmp_to(1'b0, 16'h5000);
      ph(6'h15);
      // Sensor mode skips the demagnetization step
      wr(OFS_CTRL, 32'h12);
      pulse(0);
      pulse(1);
      ph(6'h15);
      $display("test steps done");
      // Direct access: phase write commutates and loads preload
      wr(OFS_CTRL, 32'h06);
      wr(OFS_OUTCTL, 32'h00);
      pulse(0);
      chk("comm events", 6, n_comm);
      rd(OFS_OUTACT, 32'h25);
      wr(OFS_PHASE, 32'h3F);
      ph(6'h2A);
      chk("comm events", 7, n_comm);
      rd(OFS_OUTACT, 32'h00);
      wr(OFS_OUTCTL, 32'h01);
      wr(OFS_PHASE, 32'h3F);
      ph(6'h15);
      pwm <= 1'b1;
      ph(6'h3F);
      pwm <= 1'b0;
      $display("test direct done");
      // Sticky status, mask and interrupt line
      wr(OFS_STAT, 32'h0F);
      wr(OFS_MASK, 32'h00);
      wr(OFS_PHASE, 32'h3F);
      rd(OFS_STAT, 32'h01);
      chk("irq", 0, 32'(irq));
      wr(OFS_MASK, 32'h01);
      idle(2);
      chk("irq", 1, 32'(irq));
      wr(OFS_STAT, 32'h01);
      idle(2);
      chk("irq", 0, 32'(irq));
      $display("test interrupt done");
      // Overcurrent: trip, current loop, three-PWM in both modes
      opt <= 1'b0;
      wr(OFS_MASK, 32'h08);
      wr(OFS_OUTCTL, 32'h08);
      wr(OFS_CTRL, 32'h42);
      fault <= 1'b1;
      rd(OFS_CTRL, 32'h40);
      ph(6'h00);
      chk("pwm off", 0, 32'(pwm_off));
      chk("irq", 1, 32'(irq));
      fault <= 1'b0;
      wr(OFS_STAT, 32'h0F);
      wr(OFS_OUTCTL, 32'h00);
      wr(OFS_CTRL, 32'h42);
      fault <= 1'b1;
      rd(OFS_CTRL, 32'h42);
      chk("pwm off", 1, 32'(pwm_off));
      rd(OFS_STAT, 32'h08);
      fault <= 1'b0;
      wr(OFS_STAT, 32'h0F);
      wr(OFS_OUTCTL, 32'h08);
      wr(OFS_CTRL, 32'h02);
      fault <= 1'b1;
      rd(OFS_CTRL, 32'h02);
      chk("pwm off", 1, 32'(pwm_off));
      rd(OFS_STAT, 32'h00);
      wr(OFS_CTRL, 32'h6A);
      rd(OFS_CTRL, 32'h6A);
      chk("pwm off", 1, 32'(pwm_off));
      wr(OFS_CTRL, 32'h62);
      rd(OFS_CTRL, 32'h60);
      fault <= 1'b0;
      $display("test overcurrent done");
      report_and_stop();
   end
endmodule : bldc_commutation_output_config_test
